// [src/fsp_defs.svh]
// Constants for the five-stage pipeline control block.
// Assumes inclusion by bare name from files under src/.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// ==========================================
// Instruction fields
`define FSP_OPC_MSB 31
`define FSP_OPC_LSB 26
`define FSP_RX_MSB 25
`define FSP_RX_LSB 21
`define FSP_RB_MSB 20
`define FSP_RB_LSB 16
`define FSP_RT_MSB 15
`define FSP_RT_LSB 11
`define FSP_SUB_MSB 10
`define FSP_SUB_LSB 8
`define FSP_DISP_MSB 7
`define FSP_DISP_LSB 0
// ==========================================
// Reset values and sizes
`define FSP_PC_RESET 32'h00000000
`define FSP_PSW_RESET 32'h00000000
`define FSP_ADDR_STEP 32'h00000004
`define FSP_NOP_INSTR 32'h00000000
`define FSP_FILL_WORDS 3'h4
`endif

// [src/fsp_pkg.sv]
// Types shared by the pipeline control block.
// Assumes the defs header sits beside it.
package fsp_pkg;
   // ==========================================
   // Operation classes decoded from the opcode
   typedef enum logic [2:0] {
      FSP_OP_NOP = 3'h0,
      FSP_OP_ALU = 3'h1,
      FSP_OP_SHIFT = 3'h2,
      FSP_OP_LOAD = 3'h3,
      FSP_OP_STORE = 3'h4,
      FSP_OP_BRANCH = 3'h5,
      FSP_OP_SYSW = 3'h6,
      FSP_OP_SYSR = 3'h7
   } fsp_op_t;
   // Fetch sequencer states
   typedef enum logic [1:0] {
      FSP_F_RUN = 2'h0,
      FSP_F_FILL = 2'h1,
      FSP_F_MEM = 2'h2
   } fsp_fstate_t;
endpackage

// [src/fsp_regfile.sv]
// General register file: 32 words, two reads and two writes per cycle.
// Assumes the write ports never collide unless port L should win.
module fsp_regfile (
   input wire logic clk, // Processor clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [4:0] rd_x_addr, // Read port X address
   input wire logic [4:0] rd_b_addr, // Read port B address
   output logic [31:0] rd_x_data, // Read port X data
   output logic [31:0] rd_b_data, // Read port B data
   input wire logic wa_en, // Result write enable
   input wire logic [4:0] wa_addr, // Result write address
   input wire logic [31:0] wa_data, // Result write data
   input wire logic wl_en, // Load write enable
   input wire logic [4:0] wl_addr, // Load write address
   input wire logic [31:0] wl_data // Load write data
);
   logic [31:0] regs [32];
   logic [31:0] next_regs [32];
   // ==========================================
   // Two reads, two distinct addresses possible
   always_comb begin
      rd_x_data = regs[rd_x_addr];
      rd_b_data = regs[rd_b_addr];
   end
   // Per-entry write select; load port wins a same-address tie
   for (genvar i = 0; i < 32; i++) begin : g_ent
      always_comb begin
         next_regs[i] = regs[i];
         if (wa_en && wa_addr == 5'(i)) begin
            next_regs[i] = wa_data;
         end
         if (wl_en && wl_addr == 5'(i)) begin
            next_regs[i] = wl_data;
         end
      end
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            regs[i] <= 32'h00000000;
         end else begin
            regs[i] <= next_regs[i];
         end
      end
   end
endmodule

// [src/fsp_pipe.sv]
`include "fsp_defs.svh"
// Five-stage pipeline control: address, fetch, decode/read, execute, write.
// Assumes cache, translation buffer and bus interface answer combinationally
// within the cycle; fill and memory data arrive with mem_valid pulses.
module fsp_pipe (
   input wire logic clk, // Processor clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [31:0] fetched_instr_lines, // Instruction from cache
   input wire logic cache_hit, // Cache tag match
   input wire logic tlb_hit, // Translation buffer hit
   input wire logic prot_ok, // Protection check passed
   input wire logic [31:0] tlb_phys, // Translated address
   input wire logic mem_valid, // Bus unit word ready
   input wire logic [31:0] mem_data, // Bus unit read data
   input wire logic ext_interrupt, // Outside request to empty pipe
   output logic [31:0] virt_addr_bus, // Address to translation unit
   output logic virt_is_data, // High when bus carries data address
   output logic [31:0] phys_addr_bus, // Address to bus unit
   output logic mem_req, // Bus unit read or write start
   output logic mem_write, // Bus unit direction
   output logic [31:0] mem_wdata, // Store data
   output logic fill_active, // Line fill in progress
   output logic [1:0] fill_word, // Word of line being filled
   output logic tag_we, // Cache tag write strobe
   output logic [31:0] tag_addr, // Tag from address latch
   output logic fetch_irq, // Fetch interrupt recorded
   output logic irq_ack, // Interrupt acknowledge in write slot
   output logic [31:0] pc, // Program counter
   output logic [31:0] result_bus, // Write-stage result
   output logic [31:0] processor_status_word // Status word
);
   // ==========================================
   // Stage state
   logic [31:0] instruction_register, next_ir, next_pc;
   logic v_if, v_dr, v_e, v_w, next_v_if, next_v_dr, next_v_e, next_v_w;
   logic f_flt, d_flt, e_flt, w_flt;
   fsp_pkg::fsp_op_t d_op, w_op;
   logic [4:0] d_rt, w_rt;
   logic [7:0] d_disp;
   logic [31:0] operand_x_pipe_reg, operand_b_pipe_reg, w_res;
   logic [31:0] space_register, control_register;
   fsp_pkg::fsp_fstate_t fstate, next_fstate;
   logic [2:0] fill_cnt, next_fill_cnt;
   logic [31:0] phys_addr_latch, next_pal;
   logic freeze, fetch_hit, fetch_fault;
   logic [31:0] rx_data, rb_data, bus_x, bus_b, exe_res;
   logic taken, exe_ok, w_load;
   // Operand register fields of the instruction now in execute
   logic [4:0] e_rx, e_rb;
   function automatic logic [4:0] instruction_e_rx();
      return e_rx;
   endfunction
   function automatic logic [4:0] instruction_e_rb();
      return e_rb;
   endfunction
   // ==========================================
   // Fetch classification, fault ranks above miss
   always_comb begin
      fetch_fault = v_if && !(tlb_hit && prot_ok);
      fetch_hit = v_if && tlb_hit && prot_ok && cache_hit;
      freeze = (fstate != fsp_pkg::FSP_F_RUN)
         || (v_if && !fetch_fault && !cache_hit)
         || (v_e && d_op == fsp_pkg::FSP_OP_LOAD && fstate == fsp_pkg::FSP_F_RUN);
   end
   // ==========================================
   // Execute datapath with bypass from write stage
   // The bypass stands in for the delayed register write, so a result
   // produced one instruction earlier is seen without a stall
   always_comb begin
      bus_x = (v_w && !w_flt && w_rt == e_rx) ? w_res : operand_x_pipe_reg;
      bus_b = (v_w && !w_flt && w_rt == e_rb) ? w_res : operand_b_pipe_reg;
      unique case (d_op)
         fsp_pkg::FSP_OP_ALU: exe_res = bus_x + bus_b;
         fsp_pkg::FSP_OP_SHIFT: exe_res = (bus_x >> bus_b[4:0]) & ~(32'hFFFFFFFF << d_disp[4:0]);
         fsp_pkg::FSP_OP_SYSR: exe_res = d_disp[0] ? control_register : space_register;
         fsp_pkg::FSP_OP_BRANCH: exe_res = pc;
         default: exe_res = bus_b;
      endcase
      taken = v_e && !e_flt && d_op == fsp_pkg::FSP_OP_BRANCH && bus_x == bus_b;
      exe_ok = v_e && !e_flt && !freeze;
   end
   // ==========================================
   // Register file
   // Read ports follow the decode register, so operands settle in decode
   fsp_regfile u_rf (
      .clk(clk),
      .reset_n(reset_n),
      .rd_x_addr(instruction_register[`FSP_RX_MSB:`FSP_RX_LSB]),
      .rd_b_addr(instruction_register[`FSP_RB_MSB:`FSP_RB_LSB]),
      .rd_x_data(rx_data),
      .rd_b_data(rb_data),
      .wa_en(v_w && !w_flt && !freeze && (w_op == fsp_pkg::FSP_OP_ALU
         || w_op == fsp_pkg::FSP_OP_SHIFT || w_op == fsp_pkg::FSP_OP_SYSR)),
      .wa_addr(w_rt),
      .wa_data(w_res),
      .wl_en(w_load),
      .wl_addr(w_rt),
      .wl_data(mem_data)
   );
   assign w_load = fstate == fsp_pkg::FSP_F_MEM && mem_valid && !mem_write;
   // ==========================================
   // Next pipeline state; all stages move together unless frozen
   always_comb begin
      next_pc = pc;
      next_ir = instruction_register;
      next_v_if = v_if;
      next_v_dr = v_dr;
      next_v_e = v_e;
      next_v_w = v_w;
      next_fstate = fstate;
      next_fill_cnt = fill_cnt;
      next_pal = phys_addr_latch;
      if (!freeze) begin
         next_pc = taken ? pc + {{24{d_disp[7]}}, d_disp} : pc + `FSP_ADDR_STEP;
         next_v_if = 1'b1;
         next_v_dr = v_if && !taken;
         next_v_e = v_dr && !taken;
         next_v_w = v_e;
         if (fetch_hit || fetch_fault) begin
            next_ir = fetch_fault ? `FSP_NOP_INSTR : fetched_instr_lines;
         end
         if (ext_interrupt) begin
            next_v_dr = 1'b0;
            next_v_e = 1'b0;
         end
      end
      unique case (fstate)
         fsp_pkg::FSP_F_RUN: begin
            if (v_if && !fetch_fault && !cache_hit) begin
               next_fstate = fsp_pkg::FSP_F_FILL;
               next_fill_cnt = 3'h0;
               next_pal = tlb_phys;
            end else if (v_e && !e_flt && (d_op == fsp_pkg::FSP_OP_LOAD
               || d_op == fsp_pkg::FSP_OP_STORE)) begin
               next_fstate = fsp_pkg::FSP_F_MEM;
               next_pal = tlb_phys;
            end
         end
         fsp_pkg::FSP_F_FILL: begin
            if (mem_valid) begin
               next_fill_cnt = fill_cnt + 3'h1;
               if (fill_cnt + 3'h1 == `FSP_FILL_WORDS) begin
                  next_fstate = fsp_pkg::FSP_F_RUN;
                  next_ir = mem_data;
               end
            end
         end
         fsp_pkg::FSP_F_MEM: begin
            if (mem_valid) begin
               next_fstate = fsp_pkg::FSP_F_RUN;
            end
         end
         default: next_fstate = fsp_pkg::FSP_F_RUN;
      endcase
   end
   // ==========================================
   // Pipeline registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc <= `FSP_PC_RESET;
         instruction_register <= `FSP_NOP_INSTR;
         v_if <= 1'b0;
         v_dr <= 1'b0;
         v_e <= 1'b0;
         v_w <= 1'b0;
         f_flt <= 1'b0;
         d_flt <= 1'b0;
         e_flt <= 1'b0;
         w_flt <= 1'b0;
         d_op <= fsp_pkg::FSP_OP_NOP;
         w_op <= fsp_pkg::FSP_OP_NOP;
         d_rt <= 5'h00;
         w_rt <= 5'h00;
         d_disp <= 8'h00;
         e_rx <= 5'h00;
         e_rb <= 5'h00;
         operand_x_pipe_reg <= 32'h00000000;
         operand_b_pipe_reg <= 32'h00000000;
         w_res <= 32'h00000000;
         fstate <= fsp_pkg::FSP_F_RUN;
         fill_cnt <= 3'h0;
         phys_addr_latch <= 32'h00000000;
      end else begin
         pc <= next_pc;
         instruction_register <= next_ir;
         v_if <= next_v_if;
         v_dr <= next_v_dr;
         v_e <= next_v_e;
         v_w <= next_v_w;
         fstate <= next_fstate;
         fill_cnt <= next_fill_cnt;
         phys_addr_latch <= next_pal;
         if (!freeze) begin
            f_flt <= fetch_fault;
            d_flt <= f_flt;
            e_flt <= d_flt;
            w_flt <= e_flt;
            d_op <= fsp_pkg::fsp_op_t'(instruction_register[`FSP_OPC_LSB+2:`FSP_OPC_LSB]);
            d_rt <= instruction_register[`FSP_RT_MSB:`FSP_RT_LSB];
            d_disp <= instruction_register[`FSP_DISP_MSB:`FSP_DISP_LSB];
            e_rx <= instruction_register[`FSP_RX_MSB:`FSP_RX_LSB];
            e_rb <= instruction_register[`FSP_RB_MSB:`FSP_RB_LSB];
            operand_x_pipe_reg <= rx_data;
            operand_b_pipe_reg <= rb_data;
            w_op <= d_op;
            w_rt <= d_rt;
            w_res <= exe_res;
         end
      end
   end
   // ==========================================
   // Side-effect registers written only at end of a clean execute
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         space_register <= 32'h00000000;
         control_register <= 32'h00000000;
         processor_status_word <= `FSP_PSW_RESET;
      end else if (exe_ok && !ext_interrupt && d_op == fsp_pkg::FSP_OP_SYSW) begin
         unique case (d_disp[1:0])
            2'h0: space_register <= bus_b;
            2'h1: control_register <= bus_b;
            default: processor_status_word <= bus_b;
         endcase
      end
   end
   // ==========================================
   // Registered outputs toward memory units, plus interrupt and result ports
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         virt_addr_bus <= 32'h00000000;
         virt_is_data <= 1'b0;
         phys_addr_bus <= 32'h00000000;
         mem_req <= 1'b0;
         mem_write <= 1'b0;
         mem_wdata <= 32'h00000000;
         fill_active <= 1'b0;
         fill_word <= 2'h0;
         tag_we <= 1'b0;
         tag_addr <= 32'h00000000;
         fetch_irq <= 1'b0;
         irq_ack <= 1'b0;
         result_bus <= 32'h00000000;
      end else begin
         virt_is_data <= v_e && (d_op == fsp_pkg::FSP_OP_LOAD || d_op == fsp_pkg::FSP_OP_STORE);
         virt_addr_bus <= (v_e && (d_op == fsp_pkg::FSP_OP_LOAD
            || d_op == fsp_pkg::FSP_OP_STORE)) ? bus_x + {24'h000000, d_disp} : next_pc;
         phys_addr_bus <= next_pal;
         mem_req <= next_fstate != fsp_pkg::FSP_F_RUN && fstate == fsp_pkg::FSP_F_RUN;
         mem_write <= (fstate == fsp_pkg::FSP_F_RUN) ? (d_op == fsp_pkg::FSP_OP_STORE
            && next_fstate == fsp_pkg::FSP_F_MEM) : mem_write;
         mem_wdata <= bus_b;
         fill_active <= next_fstate == fsp_pkg::FSP_F_FILL;
         fill_word <= next_fill_cnt[1:0];
         tag_we <= fstate == fsp_pkg::FSP_F_FILL && next_fstate == fsp_pkg::FSP_F_RUN;
         tag_addr <= phys_addr_latch;
         fetch_irq <= !freeze && fetch_fault;
         irq_ack <= !freeze && v_e && e_flt;
         result_bus <= w_res;
      end
   end
   // A fetch fault loads an idle word, so the faulting slot carries no
   // side effects into execute and only the acknowledge reaches write
endmodule

// [test/fsp_pipe_properties.sv]
// Concurrent checks on the pipeline control ports.
// Assumes it is bound into fsp_pipe and sees only its ports.
module fsp_pipe_properties (
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic cache_hit, // Tag match
   input wire logic tlb_hit, // Translation hit
   input wire logic prot_ok, // Access allowed
   input wire logic [31:0] tlb_phys, // Translated address
   input wire logic mem_valid, // Bus word
   input wire logic ext_interrupt, // Outside request
   input wire logic mem_req, // Bus start
   input wire logic mem_write, // Bus direction
   input wire logic fill_active, // Fill running
   input wire logic [1:0] fill_word, // Fill word index
   input wire logic tag_we, // Tag write
   input wire logic [31:0] phys_addr_bus, // Physical address
   input wire logic fetch_irq, // Fetch fault
   input wire logic irq_ack, // Acknowledge slot
   input wire logic [31:0] pc, // Program counter
   input wire logic [31:0] result_bus, // Result
   input wire logic [31:0] processor_status_word // Status
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ==========================================
   // Fill sequence steps
   // Tag write is excluded because the filled line may still read as a miss then
   sequence s_miss;
      tlb_hit && prot_ok && !cache_hit && !fill_active && !tag_we;
   endsequence
   sequence s_last_word;
      fill_active && mem_valid && fill_word == 2'h3;
   endsequence
   property p_fill_start;
      s_miss |=> fill_active && mem_req && !mem_write;
   endproperty
   property p_word_step;
      fill_active && mem_valid && fill_word != 2'h3 |=> fill_word == $past(fill_word) + 2'h1;
   endproperty
   property p_fill_end;
      s_last_word |=> tag_we && !fill_active;
   endproperty
   property p_fill_addr;
      $rose(fill_active) |-> phys_addr_bus == $past(tlb_phys);
   endproperty
   property p_fault_first;
      (!tlb_hit || !prot_ok) && !cache_hit && !fill_active |=> !fill_active [*2];
   endproperty
   property p_irq_ack;
      fetch_irq |-> ##[1:4] irq_ack;
   endproperty
   property p_freeze;
      fill_active && $past(fill_active) |-> $stable(pc) && $stable(result_bus);
   endproperty
   property p_ext_block;
      ext_interrupt |=> $stable(processor_status_word);
   endproperty
   property p_req_pulse;
      mem_req |=> !mem_req;
   endproperty
   property p_tag_pulse;
      tag_we |=> !tag_we;
   endproperty
   // ==========================================
   // Assertions
   a_fill_start: assert property (p_fill_start) else $error("miss did not start fill");
   a_word_step: assert property (p_word_step) else $error("fill word did not step");
   a_fill_end: assert property (p_fill_end) else $error("tag write missing");
   a_fill_addr: assert property (p_fill_addr) else $error("fill address wrong");
   a_fault_first: assert property (p_fault_first) else $error("fill on fault");
   a_irq_ack: assert property (p_irq_ack) else $error("no acknowledge slot");
   a_freeze: assert property (p_freeze) else $error("pipe moved in fill");
   a_ext_block: assert property (p_ext_block) else $error("status written");
   a_req_pulse: assert property (p_req_pulse) else $error("bus start held");
   a_tag_pulse: assert property (p_tag_pulse) else $error("tag write held");
endmodule
bind fsp_pipe fsp_pipe_properties props (
   .clk(clk), .reset_n(reset_n), .cache_hit(cache_hit), .tlb_hit(tlb_hit), .prot_ok(prot_ok),
   .tlb_phys(tlb_phys), .mem_valid(mem_valid), .ext_interrupt(ext_interrupt),
   .mem_req(mem_req), .mem_write(mem_write), .fill_active(fill_active),
   .fill_word(fill_word), .tag_we(tag_we), .phys_addr_bus(phys_addr_bus),
   .fetch_irq(fetch_irq), .irq_ack(irq_ack), .pc(pc), .result_bus(result_bus),
   .processor_status_word(processor_status_word)
);

// [test/fsp_far_model.sv]
// Far-side model: instruction cache, translation buffer, bus unit.
// Assumes the pipe samples these answers at the rising edge.
`include "fsp_defs.svh"
module fsp_far_model (
   input wire logic clk, // Clock
   input wire logic [31:0] virt_addr_bus, // Fetch address
   input wire logic mem_req, // Bus start
   input wire logic mem_write, // Direction
   input wire logic tag_we, // Tag write
   input wire logic [31:0] miss_addr, // Line that misses
   input wire logic [31:0] fault_addr, // Line that faults
   input wire logic slow, // Gap between words
   input wire logic by_prot, // Fault kind
   output logic [31:0] fetched_instr_lines, // Instruction
   output logic cache_hit, // Tag match
   output logic tlb_hit, // Translation hit
   output logic prot_ok, // Access allowed
   output logic [31:0] tlb_phys, // Translated address
   output logic mem_valid, // Word ready
   output logic [31:0] mem_data // Word
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] PHYS_OFS = 32'h00001000;
   logic filled = 1'b0;
   logic [31:0] last_miss = 32'hFFFFFFF0;
   logic [2:0] left = 3'h0;
   logic gap = 1'b0;
   logic [2:0] nl;
   logic ng;
   logic nf;
   logic hit_fault;
   // ==========================================
   // Quiet answers before the first falling edge
   initial begin
      fetched_instr_lines = `FSP_NOP_INSTR;
      {cache_hit, tlb_hit, prot_ok, mem_valid} = 4'hE;
      tlb_phys = 32'h00000000;
      mem_data = 32'h00000000;
   end
   // Lookups answer for the address on the bus; idle bus data toggles
   always @(negedge clk) begin
      nl = mem_req ? (mem_write ? 3'h1 : `FSP_FILL_WORDS) : left;
      ng = mem_req ? slow : gap;
      nf = (last_miss == miss_addr) && (filled || tag_we);
      hit_fault = virt_addr_bus[31:4] == fault_addr[31:4];
      filled <= nf;
      last_miss <= miss_addr;
      fetched_instr_lines <= {6'h00, virt_addr_bus[25:0]}; // Opcode stays in the idle class
      cache_hit <= nf || (virt_addr_bus[31:4] != miss_addr[31:4]);
      tlb_hit <= !(hit_fault && !by_prot);
      prot_ok <= !(hit_fault && by_prot);
      tlb_phys <= virt_addr_bus + PHYS_OFS;
      if (nl != 3'h0 && !ng) begin
         mem_valid <= 1'b1;
         mem_data <= 32'hC0DE0000 + {29'h0, nl};
         left <= nl - 3'h1;
         gap <= slow;
      end else begin
         mem_valid <= 1'b0;
         mem_data <= ~mem_data;
         left <= nl;
         gap <= 1'b0;
      end
   end
endmodule

// [test/testbench.sv]
// Self-checking bench for the pipeline control block.
// Assumes the far-side model answers every lookup and bus start.
`include "fsp_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] PHYS_OFS = 32'h00001000;
   localparam logic [31:0] NO_LINE = 32'hFFFFFFF0;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_interrupt = 1'b0;
   logic slow = 1'b0;
   logic by_prot = 1'b0;
   logic [31:0] miss_addr = NO_LINE;
   logic [31:0] fault_addr = NO_LINE;
   int bad_count = 0;
   int total_checks = 0;
   logic [31:0] fetched_instr_lines, tlb_phys, mem_data, virt_addr_bus, phys_addr_bus;
   logic [31:0] mem_wdata, tag_addr, pc, result_bus, processor_status_word;
   logic cache_hit, tlb_hit, prot_ok, mem_valid, virt_is_data, mem_req, mem_write;
   logic fill_active, tag_we, fetch_irq, irq_ack;
   logic [1:0] fill_word;
   fsp_pipe dut (
      .clk(clk), .reset_n(reset_n), .fetched_instr_lines(fetched_instr_lines),
      .cache_hit(cache_hit), .tlb_hit(tlb_hit), .prot_ok(prot_ok), .tlb_phys(tlb_phys),
      .mem_valid(mem_valid), .mem_data(mem_data), .ext_interrupt(ext_interrupt),
      .virt_addr_bus(virt_addr_bus), .virt_is_data(virt_is_data),
      .phys_addr_bus(phys_addr_bus), .mem_req(mem_req), .mem_write(mem_write),
      .mem_wdata(mem_wdata), .fill_active(fill_active), .fill_word(fill_word),
      .tag_we(tag_we), .tag_addr(tag_addr), .fetch_irq(fetch_irq), .irq_ack(irq_ack),
      .pc(pc), .result_bus(result_bus), .processor_status_word(processor_status_word)
   );
   fsp_far_model far (
      .clk(clk), .virt_addr_bus(virt_addr_bus), .mem_req(mem_req), .mem_write(mem_write),
      .tag_we(tag_we), .miss_addr(miss_addr), .fault_addr(fault_addr), .slow(slow),
      .by_prot(by_prot), .fetched_instr_lines(fetched_instr_lines), .cache_hit(cache_hit),
      .tlb_hit(tlb_hit), .prot_ok(prot_ok), .tlb_phys(tlb_phys), .mem_valid(mem_valid),
      .mem_data(mem_data)
   );
   // ==========================================
   // Shared helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Just past the falling edge both sides are settled, so no race
   task automatic tick();
      @(negedge clk);
      #1;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      logic any;
      any = |{pc, result_bus, processor_status_word, virt_addr_bus, phys_addr_bus, tag_addr,
         mem_wdata, fill_word, mem_req, mem_write, fill_active, tag_we, fetch_irq, irq_ack};
      check("reset_outputs", {31'h0, any | virt_is_data}, 32'h0);
   endtask
   task automatic t_seq();
      logic [31:0] p;
      for (int i = 0; i < 4; i++) begin
         p = pc;
         tick();
         check("pc_step", pc, p + `FSP_ADDR_STEP);
         check("fetch_on_virt_bus", {31'h0, virt_is_data}, 32'h0);
         check("fetch_addr", virt_addr_bus, pc);
         check("result_idle", result_bus, 32'h0);
      end
   endtask
   // Line fill, prompt or with gaps between the words
   task automatic t_miss(input logic s);
      logic [31:0] a;
      logic [31:0] p;
      int n;
      a = (pc + 32'h40) & NO_LINE;
      slow = s;
      miss_addr = a;
      n = 0;
      for (int i = 0; i < 100 && !fill_active; i++) begin
         tick();
      end
      check("fill_req", {30'h0, mem_req, mem_write}, 32'h2);
      check("fill_addr", phys_addr_bus, a + PHYS_OFS);
      p = pc;
      for (int i = 0; i < 20 && fill_active; i++) begin
         if (mem_valid) begin
            check("fill_word", {30'h0, fill_word}, n);
            n++;
         end
         check("frozen_pc", pc, p);
         tick();
      end
      check("fill_count", n, 32'h4);
      check("tag_write", {31'h0, tag_we}, 32'h1);
      check("tag_value", tag_addr, a + PHYS_OFS);
      miss_addr = NO_LINE;
   endtask
   // A line that both faults and misses must raise the fault only
   task automatic t_fault(input logic prot);
      logic seen_fill;
      by_prot = prot;
      fault_addr = (pc + 32'h40) & NO_LINE;
      miss_addr = fault_addr;
      seen_fill = 1'b0;
      for (int i = 0; i < 100 && !fetch_irq; i++) begin
         seen_fill |= fill_active;
         tick();
      end
      check("fetch_irq", {31'h0, fetch_irq}, 32'h1);
      for (int k = 0; k < 6 && !irq_ack; k++) begin
         seen_fill |= fill_active;
         tick();
      end
      check("irq_ack", {31'h0, irq_ack}, 32'h1);
      check("no_fill_on_fault", {31'h0, seen_fill}, 32'h0);
      fault_addr = NO_LINE;
      miss_addr = NO_LINE;
      repeat (8) tick();
   endtask
   task automatic t_ext();
      logic [31:0] s;
      s = processor_status_word;
      ext_interrupt = 1'b1;
      repeat (3) tick();
      check("status_held", processor_status_word, s);
      ext_interrupt = 1'b0;
      repeat (4) tick();
   endtask
   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (4) tick();
      t_reset();
      reset_n = 1'b1;
      repeat (2) tick();
      t_seq();
      t_miss(1'b0);
      t_miss(1'b1);
      t_fault(1'b0);
      t_fault(1'b1);
      t_ext();
      end_sim();
   end
endmodule
